// ### rtl/motor_trip_map.svh
// motor trip monitor constants: register offsets, field positions, timing
// assumes inclusion by bare name from the design file and the bench
`ifndef MOTOR_TRIP_MAP_SVH
`define MOTOR_TRIP_MAP_SVH
`define ADDR_CTRL        4'h0
`define ADDR_CFG         4'h1
`define ADDR_STATUS      4'h2
`define ADDR_ALARM       4'h3
`define ADDR_IRQ_MASK    4'h4
`define ADDR_SIM_SECONDS 4'h5
`define ADDR_FAIL_SECS   4'h6
`define CTRL_TRIP_BIT    0
`define CTRL_RESET_BIT   1
`define CFG_TRIP_EN_BIT  0
`define CFG_FDBK_EN_BIT  1
`define CFG_SHED_IO_BIT  2
`define CFG_BYPASS_BIT   3
`define CFG_TYPE_LSB     4
`define ALM_INTLK_BIT    0
`define ALM_IO_BIT       1
`define ALM_TRIPF_BIT    2
`define CLOCK_HZ         100000000
`define SCAN_PERIOD_US   1000
`define SCAN_CYCLES      ((`SCAN_PERIOD_US * (`CLOCK_HZ / 1000000)))
`define SIM_SECONDS_RST  8'h02
`define FAIL_SECS_RST    8'h05
`endif

// ### rtl/motor_trip_pkg.sv
// motor trip monitor types: motor kind and displayed motor status
// assumes the map header holds all numeric constants
package motor_trip_pkg;
   typedef enum logic [1:0] {KIND_SINGLE, KIND_TWO_SPEED, KIND_REVERSING} motor_kind_t;
   typedef enum logic [2:0] {ST_STOPPED, ST_RUNNING, ST_RUN_FAST, ST_RUN_SLOW,
                             ST_RUN_FWD, ST_RUN_REV, ST_TRIPPING} motor_status_t;
endpackage

// ### rtl/hand_motor_trip_monitor.sv
// hand operated motor monitor with optional trip output, alarms and simulation
// assumes pins are asynchronous to I_CLOCK; register port is on I_CLOCK
//
// Functional notes
// - interlock alarm when running, trip enabled, interlock trips
// - bypass limits trips to non-bypassable interlocks
// - io fault alarm follows comm failure input
// - shed on io fault latches trip until reset
// - trip failure when motion persists past delay
// - simulation holds trip off, echoes working motor
// - simulated run picks running, fast or forward
// - simulated trip shows tripping then stopped
// - leaving simulation resumes real feedback and output
// - execution disable drops trip and clears alarms
// - commands before first scan discarded, trip off
// - status derived from feedback per motor kind
// - trip command while running de-energises motor
//
// register map, index equals address, data in the low bits
//   0 control, write only
//       bit 0 trip command, acted on at the next scan
//       bit 1 reset command, clears latches whose cause is gone
//   1 configuration, read and write
//       bit 0 trip function in use
//       bit 1 run feedback in use for the fail to trip timer
//       bit 2 shed the motor on an io fault
//       bit 3 interlock bypass active
//       bits 5:4 motor kind: 0 single, 1 two speed, 2 reversing
//   2 status, read only
//       bits 2:0 displayed motor status
//       bit 5 shed latch, bit 6 trip output, bit 7 simulation
//   3 alarms, read; write ones to bits 2:0 to clear them
//       bits 2:0 sticky events: interlock, io fault, trip failure
//       bits 6:4 alarm levels in the same order
//   4 interrupt mask, same layout as the sticky events
//   5 simulated tripping time in seconds
//   6 fail to trip delay in seconds
// hazards
//   commands written before the first scan are lost on purpose
//   a command written during a scan cycle waits for the next scan
`include "motor_trip_map.svh"
module hand_motor_trip_monitor #(
   parameter int SCAN_CYCLES = `SCAN_CYCLES,   // cycles between scans
   parameter int SCANS_PER_S = 1000             // scans in one second
) (
   input  wire logic                           I_CLOCK,
   input  wire logic                           I_RESET_N,
   input  wire logic                           i_fdbk_a,          // run / fast / forward contact
   input  wire logic                           i_fdbk_b,          // slow / reverse contact
   input  wire logic                           i_intlk_ok,        // bypassable interlocks ok
   input  wire logic                           i_intlk_nb_ok,     // non-bypassable interlocks ok
   input  wire logic                           i_io_comm_failure_in,
   input  wire logic                           i_sim_in,
   input  wire logic                           i_sim_run_state_in,
   input  wire logic                           i_exec_enable_in,
   input  wire logic [3:0]                     i_addr,
   input  wire logic [31:0]                    i_wdata,
   input  wire logic                           i_wr,
   input  wire logic                           i_rd,
   output logic      [31:0]                    o_rdata,
   output logic                                o_trip,
   output motor_trip_pkg::motor_status_t       o_status,
   output logic                                o_interlock_trip_alarm,
   output logic                                o_io_comm_fault_alarm,
   output logic                                o_trip_failure_alarm,
   output logic                                o_irq
);
   import motor_trip_pkg::*;

   // whole state of the block
   typedef struct packed {
      logic [1:0]    fa_s, fb_s, ik_s, nb_s, io_s, sm_s, sr_s, en_s; // synchronisers
      logic [31:0]   scan_cnt;       // scan divider
      logic          first_done;     // first scan seen
      logic          trip_cmd;       // pending operator trip
      logic          reset_cmd;      // pending reset
      logic [7:0]    cfg;            // configuration bits
      logic [7:0]    sim_secs;       // simulation echo time
      logic [7:0]    fail_secs;      // fail to trip time
      logic [2:0]    irq_mask;       // interrupt mask
      logic [2:0]    irq_stat;       // sticky event bits
      logic          trip_latch;     // trip output intent
      logic          shed_latch;     // latched shed trip
      logic [2:0]    alarm;          // alarm latches
      logic [31:0]   fail_cnt;       // scans since trip
      logic          sim_run;        // simulated motor runs
      logic [31:0]   sim_cnt;        // scans of simulated tripping
      logic          sim_tripping;   // simulated tripping phase
      motor_status_t status;
      logic          trip_out;
      logic [31:0]   rdata;
      logic          irq;
   } state_t;

   state_t s_r, s_nxt;

   // derive motion status from contacts per kind
   function automatic motor_status_t decode(input logic [1:0] kind, input logic a, input logic b);
      motor_status_t st;
      st = ST_STOPPED;
      unique case (kind)
         KIND_SINGLE:    st = a ? ST_RUNNING : ST_STOPPED;
         KIND_TWO_SPEED: st = a ? ST_RUN_FAST : (b ? ST_RUN_SLOW : ST_STOPPED);
         KIND_REVERSING: st = a ? ST_RUN_FWD : (b ? ST_RUN_REV : ST_STOPPED);
         default:        st = a ? ST_RUNNING : ST_STOPPED;
      endcase
      return st;
   endfunction

   logic scan;              // one-cycle scan enable
   logic running;           // motor shows motion
   logic trip_en;           // trip function in use
   logic intlk_bad;         // interlock demands trip
   logic [2:0] events;      // alarm rising events
   motor_status_t real_st;  // status from real contacts
   logic wr_ctrl;           // command write accepted this cycle

   // next state of the whole block
   always_comb begin
      s_nxt = s_r;
      // two-flop synchronisers for all pins
      s_nxt.fa_s = {s_r.fa_s[0], i_fdbk_a};
      s_nxt.fb_s = {s_r.fb_s[0], i_fdbk_b};
      s_nxt.ik_s = {s_r.ik_s[0], i_intlk_ok};
      s_nxt.nb_s = {s_r.nb_s[0], i_intlk_nb_ok};
      s_nxt.io_s = {s_r.io_s[0], i_io_comm_failure_in};
      s_nxt.sm_s = {s_r.sm_s[0], i_sim_in};
      s_nxt.sr_s = {s_r.sr_s[0], i_sim_run_state_in};
      s_nxt.en_s = {s_r.en_s[0], i_exec_enable_in};
      scan = (s_r.scan_cnt == 32'(SCAN_CYCLES - 1));
      s_nxt.scan_cnt = scan ? 32'h0 : s_r.scan_cnt + 32'h1;
      real_st = decode(s_r.cfg[`CFG_TYPE_LSB +: 2], s_r.fa_s[1], s_r.fb_s[1]);
      trip_en = s_r.cfg[`CFG_TRIP_EN_BIT] && s_r.en_s[1];
      intlk_bad = !s_r.nb_s[1] || (!s_r.cfg[`CFG_BYPASS_BIT] && !s_r.ik_s[1]);
      running = s_r.sm_s[1] ? s_r.sim_run : (real_st != ST_STOPPED);
      events = 3'h0;
      s_nxt.rdata = 32'h0;
      // command write that survives a coinciding scan
      wr_ctrl = i_wr && (i_addr == `ADDR_CTRL) && s_r.first_done;
      // register writes; commands only accepted after first scan
      if (i_wr) begin
         unique case (i_addr)
            `ADDR_CTRL: begin
               if (s_r.first_done) begin
                  s_nxt.trip_cmd  = s_r.trip_cmd | i_wdata[`CTRL_TRIP_BIT];
                  s_nxt.reset_cmd = s_r.reset_cmd | i_wdata[`CTRL_RESET_BIT];
               end
            end
            `ADDR_CFG:         s_nxt.cfg = i_wdata[7:0];
            `ADDR_ALARM:       s_nxt.irq_stat = s_r.irq_stat & ~i_wdata[2:0];
            `ADDR_IRQ_MASK:    s_nxt.irq_mask = i_wdata[2:0];
            `ADDR_SIM_SECONDS: s_nxt.sim_secs = i_wdata[7:0];
            `ADDR_FAIL_SECS:   s_nxt.fail_secs = i_wdata[7:0];
            default: ;
         endcase
      end
      // register reads, data next cycle
      if (i_rd) begin
         unique case (i_addr)
            `ADDR_CFG:         s_nxt.rdata = {24'h0, s_r.cfg};
            `ADDR_STATUS:      s_nxt.rdata = {24'h0, s_r.sm_s[1], s_r.trip_out, s_r.shed_latch, 2'h0, s_r.status};
            `ADDR_ALARM:       s_nxt.rdata = {25'h0, s_r.alarm, 1'b0, s_r.irq_stat};
            `ADDR_IRQ_MASK:    s_nxt.rdata = {29'h0, s_r.irq_mask};
            `ADDR_SIM_SECONDS: s_nxt.rdata = {24'h0, s_r.sim_secs};
            `ADDR_FAIL_SECS:   s_nxt.rdata = {24'h0, s_r.fail_secs};
            default:           s_nxt.rdata = 32'h0;
         endcase
      end
      // once-per-scan evaluation
      if (scan) begin
         s_nxt.first_done = 1'b1;
         // consume pending commands; one written in this very cycle waits
         s_nxt.trip_cmd = wr_ctrl && i_wdata[`CTRL_TRIP_BIT];
         s_nxt.reset_cmd = wr_ctrl && i_wdata[`CTRL_RESET_BIT];
         if (!s_r.first_done) begin
            s_nxt.trip_latch = 1'b0;
         end else if (!s_r.en_s[1]) begin
            // disabled: monitor only, alarms and latches cleared
            s_nxt.trip_latch = 1'b0;
            s_nxt.shed_latch = 1'b0;
            s_nxt.alarm = 3'h0;
            s_nxt.fail_cnt = 32'h0;
         end else begin
            // io fault alarm follows input; cleared only by reset when gone
            if (s_r.io_s[1]) begin
               if (!s_r.alarm[`ALM_IO_BIT]) events[`ALM_IO_BIT] = 1'b1;
               s_nxt.alarm[`ALM_IO_BIT] = 1'b1;
               if (trip_en && s_r.cfg[`CFG_SHED_IO_BIT]) s_nxt.shed_latch = 1'b1;
            end else if (s_r.reset_cmd) begin
               s_nxt.alarm[`ALM_IO_BIT] = 1'b0;
               s_nxt.shed_latch = 1'b0;
            end
            // interlock alarm only when running and trip function used
            if (trip_en && intlk_bad && running) begin
               if (!s_r.alarm[`ALM_INTLK_BIT]) events[`ALM_INTLK_BIT] = 1'b1;
               s_nxt.alarm[`ALM_INTLK_BIT] = 1'b1;
            end else if (s_r.reset_cmd && !intlk_bad) begin
               s_nxt.alarm[`ALM_INTLK_BIT] = 1'b0;
            end
            // trip intent: command while running, interlock, or shed
            if (trip_en && ((s_r.trip_cmd && running) || intlk_bad || s_nxt.shed_latch))
               s_nxt.trip_latch = 1'b1;
            else if (!running || !trip_en)
               s_nxt.trip_latch = 1'b0;
            // fail to trip timer counted in scans
            if (s_r.trip_latch && trip_en && s_r.cfg[`CFG_FDBK_EN_BIT] && running) begin
               if (s_r.fail_cnt >= 32'(s_r.fail_secs) * 32'(SCANS_PER_S)) begin
                  if (!s_r.alarm[`ALM_TRIPF_BIT]) events[`ALM_TRIPF_BIT] = 1'b1;
                  s_nxt.alarm[`ALM_TRIPF_BIT] = 1'b1;
               end else begin
                  s_nxt.fail_cnt = s_r.fail_cnt + 32'h1;
               end
            end else begin
               s_nxt.fail_cnt = 32'h0;
               if (s_r.reset_cmd && !running) s_nxt.alarm[`ALM_TRIPF_BIT] = 1'b0;
            end
         end
         // simulated motor
         if (s_r.sm_s[1]) begin
            if (s_r.sim_tripping) begin
               if (s_r.sim_cnt >= 32'(s_r.sim_secs) * 32'(SCANS_PER_S)) begin
                  s_nxt.sim_tripping = 1'b0;
                  s_nxt.sim_run = 1'b0;
               end else begin
                  s_nxt.sim_cnt = s_r.sim_cnt + 32'h1;
               end
            end else if (s_r.trip_latch && s_r.sim_run) begin
               s_nxt.sim_tripping = 1'b1;
               s_nxt.sim_cnt = 32'h0;
            end else if (s_r.sr_s[1] && !s_r.trip_latch) begin
               s_nxt.sim_run = 1'b1;
            end
         end else begin
            s_nxt.sim_run = 1'b0;
            s_nxt.sim_tripping = 1'b0;
         end
         // displayed status
         if (s_r.sm_s[1]) begin
            if (s_r.sim_tripping) s_nxt.status = ST_TRIPPING;
            else if (!s_r.sim_run) s_nxt.status = ST_STOPPED;
            else if (s_r.cfg[`CFG_TYPE_LSB +: 2] == 2'(KIND_TWO_SPEED)) s_nxt.status = ST_RUN_FAST;
            else if (s_r.cfg[`CFG_TYPE_LSB +: 2] == 2'(KIND_REVERSING)) s_nxt.status = ST_RUN_FWD;
            else s_nxt.status = ST_RUNNING;
         end else begin
            s_nxt.status = (s_r.trip_latch && real_st != ST_STOPPED) ? ST_TRIPPING : real_st;
         end
      end
      // trip output off in simulation and when disabled
      s_nxt.trip_out = s_nxt.trip_latch && !s_r.sm_s[1] && s_r.en_s[1] && s_r.first_done;
      // sticky events, set wins over clear
      s_nxt.irq_stat = s_nxt.irq_stat | events;
      s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
   end

   // state register
   always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         s_r <= '0;
         s_r.sim_secs <= `SIM_SECONDS_RST;
         s_r.fail_secs <= `FAIL_SECS_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from flops
   always_comb begin
      o_rdata = s_r.rdata;
      o_trip = s_r.trip_out;
      o_status = s_r.status;
      o_interlock_trip_alarm = s_r.alarm[`ALM_INTLK_BIT];
      o_io_comm_fault_alarm = s_r.alarm[`ALM_IO_BIT];
      o_trip_failure_alarm = s_r.alarm[`ALM_TRIPF_BIT];
      o_irq = s_r.irq;
   end

   // checks
   a_sim_trip_off: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
      s_r.sm_s[1] |=> !o_trip) else $error("trip driven in simulation");
   a_disable_clears: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
      (scan && s_r.first_done && !s_r.en_s[1]) |=> (s_r.alarm == 3'h0)) else $error("alarms kept when disabled");
   a_disable_no_trip: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
      !s_r.en_s[1] |=> !o_trip) else $error("trip while disabled");
   a_first_no_trip: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
      !s_r.first_done |=> !o_trip) else $error("trip before first scan");
   a_io_alarm_set: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
      (scan && s_r.first_done && s_r.en_s[1] && s_r.io_s[1]) |=> o_io_comm_fault_alarm) else $error("io alarm missed");
   a_shed_holds: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
      (s_r.shed_latch && s_r.io_s[1] && s_r.en_s[1]) |=> s_r.shed_latch) else $error("shed dropped under fault");
   a_intlk_needs_run: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
      $rose(o_interlock_trip_alarm) |-> $past(running && trip_en && intlk_bad)) else $error("interlock alarm uncaused");
   a_bypass_only_nb: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
      (s_r.cfg[`CFG_BYPASS_BIT] && s_r.nb_s[1]) |-> !intlk_bad) else $error("bypass ignored");
   a_sim_leave: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
      (scan && !s_r.sm_s[1]) |=> !s_r.sim_run) else $error("sim motor kept");
   // interlock and trip decisions taken at a scan
   a_bypass_off_any: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
      (!s_r.cfg[`CFG_BYPASS_BIT] && !s_r.ik_s[1]) |-> intlk_bad) else $error("bypassable fault ignored");
   a_intlk_alarm_set: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
      (scan && s_r.first_done && trip_en && intlk_bad && running) |=> o_interlock_trip_alarm) else $error("interlock alarm missed");
   a_cmd_running: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
      (scan && s_r.first_done && trip_en && s_r.trip_cmd && running) |=> s_r.trip_latch) else $error("trip command lost");
   a_shed_trips: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
      (scan && s_r.first_done && trip_en && s_r.cfg[`CFG_SHED_IO_BIT] && s_r.io_s[1]) |=> s_r.trip_latch)
      else $error("shed did not trip");
   a_trip_needs_en: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
      (scan && s_r.first_done && !trip_en) |=> !s_r.trip_latch) else $error("trip kept without trip function");
   a_ctrl_dropped: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
      !s_r.first_done |=> !s_r.trip_cmd) else $error("early command kept");
   // alarm latches and the fail to trip timer
   a_tripf_needs_run: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
      $rose(o_trip_failure_alarm) |-> $past(running && s_r.trip_latch)) else $error("trip failure uncaused");
   a_fail_cnt_idle: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
      (scan && !s_r.trip_latch) |=> (s_r.fail_cnt == 32'h0)) else $error("fail timer runs without trip");
   a_io_alarm_kept: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
      (o_io_comm_fault_alarm && s_r.io_s[1] && s_r.en_s[1]) |=> o_io_comm_fault_alarm) else $error("io alarm dropped");
   a_intlk_clear_ok: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
      $fell(o_interlock_trip_alarm) |-> $past(!intlk_bad || !s_r.en_s[1])) else $error("interlock alarm cleared early");
   // displayed status and the simulated motor
   a_status_steady: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
      !scan |=> $stable(o_status)) else $error("status moved between scans");
   a_real_status: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
      (scan && !s_r.sm_s[1] && !s_r.trip_latch) |=> (o_status == $past(real_st))) else $error("status not from contacts");
   a_sim_run_set: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
      (scan && s_r.sm_s[1] && s_r.sr_s[1] && !s_r.trip_latch && !s_r.sim_tripping) |=> s_r.sim_run)
      else $error("simulated run ignored");
   a_sim_no_run_trip: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
      (scan && s_r.sm_s[1] && s_r.trip_latch && !s_r.sim_tripping && !s_r.sim_run) |=> !s_r.sim_run)
      else $error("simulated start while tripped");
   a_sim_trip_start: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
      (scan && s_r.sm_s[1] && !s_r.sim_tripping && s_r.trip_latch && s_r.sim_run) |=> s_r.sim_tripping)
      else $error("simulated trip not started");
   a_sim_status: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
      (scan && s_r.sm_s[1] && s_r.sim_tripping) |=> (o_status == ST_TRIPPING)) else $error("tripping not shown");
   a_leave_sim_trip: assert property (@(posedge I_CLOCK) disable iff (!I_RESET_N)
      (!s_r.sm_s[1] && s_r.en_s[1] && s_r.first_done) |=> (o_trip == $past(s_nxt.trip_latch)))
      else $error("real trip output not driven");
   c_shed_trip: cover property (@(posedge I_CLOCK) $rose(s_r.shed_latch));
   c_intlk_alarm: cover property (@(posedge I_CLOCK) $rose(o_interlock_trip_alarm));
   c_disabled_scan: cover property (@(posedge I_CLOCK) scan && s_r.first_done && !s_r.en_s[1]);
   c_trip_fail: cover property (@(posedge I_CLOCK) $rose(o_trip_failure_alarm));
   c_sim_tripping: cover property (@(posedge I_CLOCK) o_status == ST_TRIPPING && s_r.sm_s[1]);
endmodule

// ### bench/motor_starter_model.sv
// behavioural motor and starter seen from the trip output and feedback contacts
// assumes trip high opens the starter; an open contact reads low
module motor_starter_model #(
   parameter int STOP_CYCLES = 16            // coast-down time once the starter opens
) (
   input  wire logic clk,
   input  wire logic i_hand_run,             // local start switch held on
   input  wire logic i_use_b,                // run on the second contact (slow or reverse)
   input  wire logic i_stuck,                // welded contactor: trip has no effect
   input  wire logic i_trip,                 // trip output of the monitor
   output logic      o_fdbk_a,
   output logic      o_fdbk_b
);
   timeunit 1ns;
   timeprecision 1ps;
   int   coast = 0;                          // cycles since the starter opened
   logic spin  = 1'b0;                       // shaft turning
   logic held  = 1'b0;                       // starter tripped out until the hand switch reopens
   // shaft follows the hand switch, stops a while after a working trip and stays stopped
   always @(posedge clk) begin
      if (!i_hand_run) begin
         coast <= 0;
         held  <= 1'b0;
         spin  <= 1'b0;
      end else if (i_trip && !i_stuck) begin
         coast <= coast + 1;
         if (coast >= STOP_CYCLES) begin
            spin <= 1'b0;
            held <= 1'b1;
         end
      end else begin
         coast <= 0;
         spin  <= !held;
      end
   end
   // contacts close only while turning, on the selected side
   assign o_fdbk_a = spin & ~i_use_b;
   assign o_fdbk_b = spin & i_use_b;
endmodule

// ### bench/tb.sv
// self-checking bench for the hand motor trip monitor
// assumes the starter model on the contacts; scans shortened to 4 cycles
`include "motor_trip_map.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import motor_trip_pkg::*;
   localparam int SCAN = 4;                  // cycles per scan
   localparam int SPS  = 2;                  // scans per second
   localparam int FAIL_SCANS = 5 * SPS;      // fail-to-trip delay after reset
   localparam int SIM_SCANS  = 2 * SPS;      // simulated tripping time after reset
   logic clk = 1'b0, rst_n = 1'b0, hand = 1'b0, use_b = 1'b0, stuck = 1'b0;
   logic ok = 1'b1, nb_ok = 1'b1, io_fail = 1'b0, sim = 1'b0, sim_run = 1'b0, en = 1'b1;
   logic wr = 1'b0, rd = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, v;
   logic fa, fb, trip, a_int, a_io, a_tf, irq;
   motor_status_t st;
   motor_status_t run_st [3] = '{ST_RUNNING, ST_RUN_FAST, ST_RUN_FWD};
   logic [3:0] ilk [4] = '{4'h3, 4'h5, 4'hA, 4'hD};  // bypass, ok, nb_ok, trip expected
   int num_errors = 0, samples_checked = 0;
   always #5 clk = ~clk;
   hand_motor_trip_monitor #(.SCAN_CYCLES(SCAN), .SCANS_PER_S(SPS)) DUT (
      .I_CLOCK(clk), .I_RESET_N(rst_n), .i_fdbk_a(fa), .i_fdbk_b(fb), .i_intlk_ok(ok),
      .i_intlk_nb_ok(nb_ok), .i_io_comm_failure_in(io_fail), .i_sim_in(sim),
      .i_sim_run_state_in(sim_run), .i_exec_enable_in(en), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_trip(trip), .o_status(st),
      .o_interlock_trip_alarm(a_int), .o_io_comm_fault_alarm(a_io),
      .o_trip_failure_alarm(a_tf), .o_irq(irq));
   motor_starter_model motor (.clk(clk), .i_hand_run(hand), .i_use_b(use_b), .i_stuck(stuck),
      .i_trip(trip), .o_fdbk_a(fa), .o_fdbk_b(fb));
   // compare one value and count it
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   // one-cycle write strobe
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1; addr <= a; wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // one-cycle read strobe, data taken in the following cycle
   task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      rd <= 1'b1; addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // let whole scans go by, then sample settled outputs
   task automatic scans(input int n);
      repeat (n * SCAN) @(posedge clk);
      #1;
   endtask
   // command word, then time for the next scans to act on it
   task automatic cmd(input logic [31:0] d);
      wr_reg(`ADDR_CTRL, d);
      scans(2);
   endtask
   // fresh reset in mid-run, then configuration
   task automatic restart(input logic [31:0] cfg);
      @(posedge clk);
      rst_n <= 1'b0;
      hand  <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      hand  <= 1'b1;
      scans(3);
      wr_reg(`ADDR_CFG, cfg);
      scans(3);
   endtask
   // counts, verdict and end of run
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // watchdog far beyond the expected run length
   initial begin
      #300000;
      num_errors++;
      give_verdict();
   end
   initial begin
      hand <= 1'b1;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      // trip command before the first scan is dropped
      wr_reg(`ADDR_CFG, 32'h3);
      wr_reg(`ADDR_CTRL, 32'h1);
      scans(3);
      chk(trip, 1'h0);
      chk(st, ST_RUNNING);
      rd_reg(`ADDR_SIM_SECONDS, v); chk(v, 32'h2);
      rd_reg(`ADDR_FAIL_SECS, v); chk(v, 32'h5);
      rd_reg(`ADDR_CFG, v); chk(v, 32'h3);
      rd_reg(4'hF, v); chk(v, 32'h0);
      // trip a running motor that stops in time
      cmd(32'h1);
      chk(trip, 1'h1);
      scans(FAIL_SCANS + 4);
      chk(st, ST_STOPPED);
      chk(a_tf, 1'h0);
      // trip a welded motor: failure alarm after the delay, kept while motion lasts
      stuck <= 1'b1;
      restart(32'h3);
      wr_reg(`ADDR_IRQ_MASK, 32'h4);
      cmd(32'h1);
      scans(FAIL_SCANS - 6);
      chk(a_tf, 1'h0);
      scans(8);
      chk(a_tf, 1'h1);
      chk(irq, 1'h1);
      wr_reg(`ADDR_ALARM, 32'h4);
      scans(1);
      chk(irq, 1'h0);
      cmd(32'h2);
      chk(a_tf, 1'h1);
      stuck <= 1'b0;
      // interlock cases with and without bypass, then reset of the alarm
      for (int i = 0; i < 4; i++) begin
         restart({28'h0, ilk[i][3], 3'h3});
         ok <= ilk[i][2];
         nb_ok <= ilk[i][1];
         scans(3);
         chk(trip, ilk[i][0]);
         chk(a_int, ilk[i][0]);
         ok <= 1'b1;
         nb_ok <= 1'b1;
         scans(2);
         cmd(32'h2);
         chk(a_int, 1'h0);
      end
      // communication loss with shedding, latched until reset once cleared
      restart(32'h7);
      wr_reg(`ADDR_IRQ_MASK, 32'h2);
      io_fail <= 1'b1;
      scans(3);
      chk(a_io, 1'h1);
      chk(trip, 1'h1);
      chk(irq, 1'h1);
      cmd(32'h2);
      chk(trip, 1'h1);
      io_fail <= 1'b0;
      scans(3);
      chk(trip, 1'h1);
      wr_reg(`ADDR_ALARM, 32'h2);
      cmd(32'h2);
      chk(trip, 1'h0);
      chk(irq, 1'h0);
      // masked fault, then execution disable drops trip and alarms
      wr_reg(`ADDR_IRQ_MASK, 32'h0);
      io_fail <= 1'b1;
      scans(3);
      chk(irq, 1'h0);
      en <= 1'b0;
      scans(3);
      chk(trip, 1'h0);
      chk(a_io, 1'h0);
      en <= 1'b1;
      io_fail <= 1'b0;
      // simulation of each motor kind while the real motor runs reverse
      use_b <= 1'b1;
      sim <= 1'b1;
      sim_run <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         restart({26'h0, 2'(k), 4'h3});
         chk(st, run_st[k]);
         chk(trip, 1'h0);
      end
      sim <= 1'b0;
      scans(3);
      chk(st, ST_RUN_REV);
      sim <= 1'b1;
      scans(3);
      cmd(32'h1);
      sim_run <= 1'b0;
      scans(1);
      chk(st, ST_TRIPPING);
      chk(trip, 1'h0);
      scans(SIM_SCANS + 2);
      chk(st, ST_STOPPED);
      give_verdict();
   end
endmodule
